// [pkg/igb_pkg.sv]
// Purpose: Shared constants for the intensifier gate and plate bracket block
// Assumes: pclk at 200 MHz, APB registers one aligned 32-bit word each
// Notes: Times kept in ns, rates in kHz or Hz, cycle counts derived from the clock rate
package igb_pkg;
   localparam int CLK_MHZ = 200;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DELAY = 8'h04;
   localparam logic [7:0] OFS_WIDTH = 8'h08;
   localparam logic [7:0] OFS_AUX = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // Control field positions
   localparam int CTRL_GATE_MODE = 0;
   localparam int CTRL_BRACKET = 1;
   // Reset values
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [15:0] WIDTH_RST = 16'h0001;
   localparam logic [15:0] AUX_RST = 16'h0000;
   // Times as printed
   localparam int BRACKET_ADD_NS = 10;
   localparam int MIN_DELAY_NS = 25;
   localparam int MIN_DELAY_BR_NS = 35;
   localparam int PLATE_ON_NS = 35;
   localparam int PLATE_OFF_NS = 1000;
   localparam int T0_INSERT_NS = 12;
   localparam int RATE_FAST_KHZ = 1000;
   localparam int RATE_BR_HZ = 6250;
   // Derived cycle counts: every time and period rounds up to whole cycles
   localparam logic [15:0] BRACKET_ADD_CYC = 16'((BRACKET_ADD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] MIN_DELAY_CYC = 16'((MIN_DELAY_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] MIN_DELAY_BR_CYC = 16'((MIN_DELAY_BR_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] PLATE_ON_CYC = 16'((PLATE_ON_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] PLATE_OFF_CYC = 16'((PLATE_OFF_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] T0_CYC = 16'((T0_INSERT_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] PERIOD_FAST_CYC = 16'((CLK_MHZ * 1000 + RATE_FAST_KHZ - 1) / RATE_FAST_KHZ);
   // Bracket period exceeds 4096 cycles, so the top module takes it as a parameter
   localparam int PERIOD_BR_CYC = (CLK_MHZ * 1000000 + RATE_BR_HZ - 1) / RATE_BR_HZ;
   // Sequencer states, Gray from ST_IDLE to ST_HOLD; the return to ST_IDLE flips three bits
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DELAY = 3'b001,
      ST_GATE = 3'b011,
      ST_TAIL = 3'b010,
      ST_READ = 3'b110,
      ST_HOLD = 3'b111
   } igb_state_type;
endpackage : igb_pkg

// [design/igb_gate_seq.sv]
// Purpose: Trigger-driven gate ensemble, plate bracketing and readout interlock
// Assumes: Inputs synchronous to pclk; APB slave with one wait state
// Notes: One elapsed-time counter, run from the trigger edge and restarted at the gate stop
//    Readout is interlocked at trigger time; a busy readout refuses the trigger
//    Bracket timing comes from constants, the host only turns it on or off

// Summary of operation
// R01 - Gate mode uses internal sync timing only
// R02 - Start one readout after each ensemble
// R03 - Hold readout while generator is busy
// R04 - No photocathode pulse during readout
// R05 - Host zeroes exposure, disables cleans, shutter open
// R06 - Ensemble: start, stop, at least one aux
// R07 - Bracketing keeps plate off outside gate interval
// R08 - Plate on before gate, off after it
// R09 - Bracketing adds 10 ns gate delay
// R10 - Minimum delay 25 ns, 35 ns bracketed
// R11 - Repetition 6.25 kHz bracketed, 1 MHz otherwise
// R12 - Plate on 35 ns early, 1 us after
// R13 - Host avoids bracketing under 35 ns delay
// R14 - Time zero about 12 ns after trigger
// R15 - Bracketed gate no earlier than 35 ns
// R16 - Host enables bracketing by explicit selection
// R17 - No bracketing with third-generation intensifier
// R18 - Photocathode on only during gate pulse
// R19 - Safe mode holds photocathode off
// R20 - Overlight alarm disables photocathode
// R21 - Gate opens on start, closes on stop
module igb_gate_seq #(
   parameter int PERIOD_BR = igb_pkg::PERIOD_BR_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Trigger and status inputs
   input wire logic trigger_in,
   input wire logic overlight_alarm,
   input wire logic gen3_fitted,
   input wire logic readout_busy,
   // Intensifier drives
   output logic photocathode_gate,
   output logic microchannel_plate,
   output logic time_zero_marker,
   // Ensemble pulses and readout handshake
   output logic gate_start,
   output logic gate_stop,
   output logic aux_pulse,
   output logic generator_busy,
   output logic readout_start
);
   import igb_pkg::*;
   // Everything below runs on pclk with the one asynchronous reset

   // Larger of two counts
   // Shared by every clamp to a minimum value
   function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
      max16 = (a > b) ? a : b;
   endfunction : max16

   // Software registers
   logic [1:0] ctrl;
   logic [15:0] delay;
   logic [15:0] width;
   logic [15:0] aux;
   // Sequencer state
   igb_state_type state;
   igb_state_type next_state;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   // Previous trigger sample for edge detection
   logic trig_prev;
   // One aux pulse per ensemble
   logic aux_done;
   // Gate level before the safety masks
   logic gate_q;
   logic next_gate;
   logic next_plate;

   // Bus decode
   // First access cycle; the registered pready blocks a second take
   wire acc = psel && penable && !pready;
   // Writes land only on the edge that completes the transfer
   wire wr = psel && penable && pready && pwrite;
   // One address compare per register
   wire hit_ctrl = (paddr == OFS_CTRL);
   wire hit_delay = (paddr == OFS_DELAY);
   wire hit_width = (paddr == OFS_WIDTH);
   wire hit_aux = (paddr == OFS_AUX);
   wire hit_stat = (paddr == OFS_STATUS);
   // Anything else answers with an error
   wire mapped = hit_ctrl | hit_delay | hit_width | hit_aux | hit_stat;

   // Mode decode; a third-generation tube never sees bracketing [R17]
   wire gate_mode = ctrl[CTRL_GATE_MODE];
   wire bracket = ctrl[CTRL_BRACKET] && !gen3_fitted; // [R17]
   // Photocathode allowed only in gate mode without alarm [R19] [R20]
   wire pc_allow = gate_mode && !overlight_alarm; // [R19] [R20]

   // Effective gate delay: clamp to minimum, add bracket insertion [R09] [R10] [R15]
   wire [15:0] min_dly = bracket ? MIN_DELAY_BR_CYC : MIN_DELAY_CYC; // [R10]
   wire [15:0] add_dly = bracket ? BRACKET_ADD_CYC : 16'h0000; // [R09]
   wire [15:0] base_dly = max16(delay, MIN_DELAY_CYC);
   wire [15:0] eff_dly = max16(16'(base_dly + add_dly), min_dly); // [R15]
   // Width never shorter than one cycle
   wire [15:0] eff_wid = max16(width, 16'h0001);
   // Stop point counts on from the start point
   wire [15:0] stop_at = 16'(eff_dly + eff_wid);
   // Plate opens a fixed lead ahead of the gate [R08] [R12]
   wire [15:0] plate_at = 16'(eff_dly - PLATE_ON_CYC); // [R12]
   // Repetition spacing counted on from the gate stop [R11]
   wire [15:0] period = bracket ? 16'(PERIOD_BR) : PERIOD_FAST_CYC; // [R11]
   // Time zero insertion only in bracket mode [R14]
   wire [15:0] t0_at = bracket ? T0_CYC : 16'h0000; // [R14]

   // Trigger edge; ignored outside gate mode or during readout [R01] [R04]
   wire trig_edge = trigger_in && !trig_prev;
   wire start_ok = trig_edge && gate_mode && !readout_busy; // [R01] [R04]
   // Start point, only while counting the delay
   wire hit_start = (state == ST_DELAY) && (cnt == eff_dly);
   // Stop point, only while the gate is open
   wire hit_stop = (state == ST_GATE) && (cnt == stop_at);
   // Aux at its delay, or forced with the stop so an ensemble never lacks it [R06]
   wire hit_aux_n = (state == ST_DELAY || state == ST_GATE) && !aux_done &&
                    ((cnt == aux) || hit_stop); // [R06]

   // Sequencer next state
   always_comb begin
      next_state = state;
      next_cnt = 16'(cnt + 16'h0001);
      next_gate = gate_q;
      next_plate = microchannel_plate;
      case (state)
         ST_IDLE: begin
            // Waiting for an accepted trigger, gate and bracketed plate off
            next_cnt = 16'h0000;
            next_gate = 1'b0;
            next_plate = 1'b0; // [R07]
            if (start_ok) begin
               next_state = ST_DELAY;
            end
         end
         ST_DELAY: begin
            // Plate lead ahead of the gate [R08] [R12]
            if (bracket && cnt == plate_at) begin
               next_plate = 1'b1; // [R08] [R12]
            end
            if (hit_start) begin
               next_gate = 1'b1; // [R21]
               next_state = ST_GATE;
            end
         end
         ST_GATE: begin
            // Gate open until the stop point
            if (hit_stop) begin
               next_gate = 1'b0; // [R21]
               next_cnt = 16'h0000;
               next_state = ST_TAIL;
            end
         end
         ST_TAIL: begin
            // Plate stays up for the fall time after the gate [R12]
            if (!bracket || cnt >= PLATE_OFF_CYC) begin
               next_plate = 1'b0; // [R07] [R12]
               next_state = ST_READ;
            end
         end
         ST_READ: begin
            // Ensemble finished; readout launched once [R02] [R03]
            next_state = ST_HOLD;
         end
         ST_HOLD: begin
            // Spacing counted past trigger plus ensemble keeps rate capped [R11]
            if (cnt >= period) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            // Unused code falls back to idle with drives off
            next_state = ST_IDLE;
            next_gate = 1'b0;
            next_plate = 1'b0;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Idle with the count cleared
         state <= ST_IDLE;
         cnt <= 16'h0000;
         trig_prev <= 1'b0;
         gate_q <= 1'b0;
         aux_done <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         trig_prev <= trigger_in;
         gate_q <= next_gate;
         aux_done <= (state == ST_IDLE) ? 1'b0 : (aux_done | hit_aux_n);
      end
   end

   // Intensifier outputs; photocathode follows gate only when allowed [R18]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Both biases off while in reset
         photocathode_gate <= 1'b0;
         microchannel_plate <= 1'b0;
         time_zero_marker <= 1'b0;
      end else begin
         photocathode_gate <= next_gate && pc_allow; // [R18] [R19] [R20]
         // Without bracketing the plate simply follows the gate mode [R07]
         microchannel_plate <= bracket ? next_plate : gate_mode; // [R07]
         // Marker pulse placed in the delay count
         time_zero_marker <= (state == ST_DELAY) && (cnt == t0_at); // [R14]
      end
   end

   // Ensemble pulses and readout interlock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // No pulses and no busy while in reset
         gate_start <= 1'b0;
         gate_stop <= 1'b0;
         aux_pulse <= 1'b0;
         generator_busy <= 1'b0;
         readout_start <= 1'b0;
      end else begin
         gate_start <= hit_start; // [R06]
         gate_stop <= hit_stop; // [R06]
         aux_pulse <= hit_aux_n; // [R06]
         // Busy covers the whole ensemble so readout waits for it [R03]
         generator_busy <= (next_state == ST_DELAY) || (next_state == ST_GATE) ||
                           (next_state == ST_TAIL); // [R03]
         // One pulse per finished ensemble
         readout_start <= (state == ST_READ); // [R02] [R03]
      end
   end

   // Register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Safe mode and shortest timing after reset
         ctrl <= CTRL_RST;
         delay <= DELAY_RST;
         width <= WIDTH_RST;
         aux <= AUX_RST;
      end else begin
         // Mode bits; upper bits of the word are dropped
         if (wr && hit_ctrl) begin
            ctrl <= pwdata[1:0]; // [R16]
         end
         // Gate delay in cycles, clamped on use
         if (wr && hit_delay) begin
            delay <= pwdata[15:0];
         end
         // Gate width in cycles, clamped on use
         if (wr && hit_width) begin
            width <= pwdata[15:0];
         end
         // Aux offset in cycles from the trigger
         if (wr && hit_aux) begin
            aux <= pwdata[15:0];
         end
      end
   end

   // Read mux; status shows live sequencer state
   // Unused upper bits read as zero
   wire [31:0] status = {24'h0000_00, state, overlight_alarm, gen3_fitted, bracket,
                         readout_busy, generator_busy};
   wire [31:0] rd_mux = hit_ctrl ? {30'h0000_0000, ctrl} :
                        hit_delay ? {16'h0000, delay} :
                        hit_width ? {16'h0000, width} :
                        hit_aux ? {16'h0000, aux} :
                        hit_stat ? status : 32'h0000_0000;

   // APB answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Bus quiet while in reset
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= acc;
         // Error only for unmapped addresses
         pslverr <= acc && !mapped;
         // Read data stands only with pready, zero otherwise
         prdata <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end
endmodule : igb_gate_seq

// [bench/igb_seq_props.sv]
// Purpose: Port-level timing checks for the gate sequencer
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bracket mode is not visible at the ports, so checks hold in both modes
module igb_seq_props #(
   parameter int PERIOD_BR = 32000
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Intensifier drives and pulses
   input wire logic photocathode_gate,
   input wire logic microchannel_plate,
   input wire logic gate_start,
   input wire logic gate_stop,
   input wire logic generator_busy,
   input wire logic readout_start,
   // Status inputs
   input wire logic readout_busy,
   input wire logic overlight_alarm
);
   timeunit 1ns;
   timeprecision 1ps;
   // Cycles since the last gate start, saturating
   logic [15:0] since;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Saturates so the first gate after reset never trips the rate check
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         since <= 16'hffff;
      else if (gate_start)
         since <= 16'h0000;
      else if (since != 16'hffff)
         since <= since + 16'h0001;
   end
   property p_open; $rose(photocathode_gate) |-> gate_start; endproperty
   a_open: assert property (p_open) else $error("gate rose without start");
   property p_close; gate_stop |-> !photocathode_gate; endproperty
   a_close: assert property (p_close) else $error("gate high at stop");
   property p_alarm; overlight_alarm |=> !photocathode_gate; endproperty
   a_alarm: assert property (p_alarm) else $error("gate on under alarm");
   property p_rd_block; readout_busy |=> !$rose(photocathode_gate); endproperty
   a_rd_block: assert property (p_rd_block) else $error("gate during readout");
   property p_rd_hold; generator_busy |-> !readout_start; endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("readout while busy");
   property p_rd_after; $fell(generator_busy) |-> ##[0:2] readout_start; endproperty
   a_rd_after: assert property (p_rd_after) else $error("no readout after ensemble");
   property p_cover; photocathode_gate |-> microchannel_plate; endproperty
   a_cover: assert property (p_cover) else $error("plate off during gate");
   property p_lead; $rose(photocathode_gate) |-> $past(microchannel_plate, 7); endproperty
   a_lead: assert property (p_lead) else $error("plate late before gate");
   property p_tail; $fell(photocathode_gate) |-> microchannel_plate [*8]; endproperty
   a_tail: assert property (p_tail) else $error("plate dropped early");
   property p_rate; gate_start |-> since >= 16'h00c7; endproperty
   a_rate: assert property (p_rate) else $error("gate rate too high");
   c_gate: cover property (gate_start ##1 photocathode_gate);
   c_read: cover property (readout_start);
   c_plate: cover property ($fell(microchannel_plate));
endmodule : igb_seq_props

bind igb_gate_seq igb_seq_props #(.PERIOD_BR(PERIOD_BR)) u_props (
   .pclk(pclk), .presetn(presetn), .photocathode_gate(photocathode_gate),
   .microchannel_plate(microchannel_plate), .gate_start(gate_start),
   .gate_stop(gate_stop), .generator_busy(generator_busy),
   .readout_start(readout_start), .readout_busy(readout_busy),
   .overlight_alarm(overlight_alarm));

// [bench/igb_far_model.sv]
// Purpose: Trigger source and sensor readout on the far side
// Assumes: Driven from the bench clock
// Notes: Readout length is set per shot, zero gives a prompt readout
module igb_far_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench controls
   input wire logic fire,
   input wire logic hold,
   input wire logic [7:0] rd_len,
   // From the sequencer
   input wire logic readout_start,
   // To the sequencer
   output logic trigger_in,
   output logic readout_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // Trigger pulse and readout counters
   logic [1:0] trig_cnt;
   logic [7:0] rd_cnt;
   // Trigger held three cycles so the edge is seen once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_cnt <= 2'h0;
         rd_cnt <= 8'h00;
      end else begin
         trig_cnt <= fire ? 2'h3 : trig_cnt - 2'(trig_cnt != 2'h0);
         rd_cnt <= readout_start ? rd_len : rd_cnt - 8'(rd_cnt != 8'h00);
      end
   end
   assign trigger_in = trig_cnt != 2'h0;
   // Hold lets the bench keep a readout running
   assign readout_busy = hold || rd_cnt != 8'h00;
endmodule : igb_far_model

// [bench/test_intensifier_gate_bracket_timing.sv]
// Purpose: Self-checking bench for the gate sequencer
// Assumes: 200 MHz pclk, bracket period shortened to 300 cycles
// Notes: Expected timing rebuilt from the delay rules with integers
module test_intensifier_gate_bracket_timing;
   timeunit 1ns;
   timeprecision 1ps;
   import igb_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, fire, hold, gen3_fitted, overlight_alarm;
   logic [7:0] paddr, rd_len;
   logic [31:0] pwdata, prdata, rv;
   logic pready, pslverr, se, trigger_in, readout_busy, photocathode_gate, microchannel_plate;
   logic time_zero_marker, gate_start, gate_stop, aux_pulse, generator_busy, readout_start;
   int err_count, checked, seed, k, gs, ge, tz, pr, pf, gh, na, nr;
   // Register map walk, last entry unmapped
   logic [7:0] ra [5] = '{OFS_CTRL, OFS_DELAY, OFS_WIDTH, OFS_AUX, 8'h20};
   logic [31:0] rx [5] = '{32'(CTRL_RST), 32'(DELAY_RST), 32'(WIDTH_RST), 32'(AUX_RST), 0};
   igb_gate_seq #(.PERIOD_BR(300)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_in, .overlight_alarm,
      .gen3_fitted, .readout_busy, .photocathode_gate, .microchannel_plate,
      .time_zero_marker, .gate_start, .gate_stop, .aux_pulse, .generator_busy,
      .readout_start);
   igb_far_model far_u (.pclk, .presetn, .fire, .hold, .rd_len, .readout_start,
      .trigger_in, .readout_busy);
   // 5 ns clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer, request held until pready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rv = prdata;
      se = pslverr;
      {psel, penable} <= 2'b00;
      if (i == 20) begin
         err_count++;
         close_out;
      end
   endtask : apb
   // Gate delay in cycles after clamping to the minimum
   function automatic int exp_d(int dl, bit b);
      int d;
      d = (dl < int'(MIN_DELAY_CYC) ? int'(MIN_DELAY_CYC) : dl) + (b ? int'(BRACKET_ADD_CYC) : 0);
      return (b && d < int'(MIN_DELAY_BR_CYC)) ? int'(MIN_DELAY_BR_CYC) : d;
   endfunction : exp_d
   // Configure, fire a trigger and a second one at loop step 100, record pulse times
   task automatic shot(input int dl, input int wd, input int ax, input logic [1:0] c, input bit acc);
      int i;
      bit b;
      apb(1'b1, OFS_DELAY, 32'(dl));
      apb(1'b1, OFS_WIDTH, 32'(wd));
      apb(1'b1, OFS_AUX, 32'(ax));
      // Exposure, cleans and shutter are held by the host, outside this block
      apb(1'b1, OFS_CTRL, {30'h0, c});
      b = c[1] && !gen3_fitted;
      {gs, ge, tz, pr, pf} = {5{32'hffff_ffff}};
      {gh, na, nr} = {3{32'h0000_0000}};
      repeat (4) @(posedge pclk);
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      for (i = 0; i < 1500; i++) begin
         @(posedge pclk);
         // Second trigger inside the tail or hold time must be refused
         fire <= (i == 100);
         if (gate_start === 1'b1) gs = i;
         if (gate_stop === 1'b1) ge = i;
         if (time_zero_marker === 1'b1) tz = i;
         if (aux_pulse === 1'b1) na++;
         if (readout_start === 1'b1) nr++;
         if (photocathode_gate === 1'b1) gh++;
         if (microchannel_plate === 1'b1 && pr < 0) pr = i;
         if (microchannel_plate !== 1'b1 && pr >= 0 && pf < 0) pf = i;
      end
      if (!acc) begin
         chk(32'(gs), 32'hffff_ffff);
         chk(32'(gh), 0);
      end else begin
         chk(32'(gs - tz), 32'(exp_d(dl, b) - (b ? int'(T0_CYC) : 0)));
         chk(32'(ge - gs), 32'(wd));
         chk(32'(gh), overlight_alarm ? 0 : 32'(wd));
         chk(32'(na), 1);
         chk(32'(nr), 1);
         chk(32'(b ? (gs - pr >= 7 && gs - pr <= 8) : pr == 0), 1);
         if (b)
            chk(32'(pf - ge >= int'(PLATE_OFF_CYC) && pf - ge <= 202), 1);
      end
      $display("shot done delay %0d bracket %0d", dl, b);
   endtask : shot
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
      {fire, hold, rd_len, gen3_fitted, overlight_alarm} = 0;
      err_count = 0;
      checked = 0;
      seed = 66;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (k = 0; k < 5; k++) begin
         apb(1'b0, ra[k], 32'h0000_0000);
         chk(rv, rx[k]);
         chk(32'(se), 32'(k == 4));
      end
      $display("register walk done");
      for (k = 0; k < 8; k++) begin
         gen3_fitted <= (k == 6);
         overlight_alarm <= (k == 7);
         rd_len <= k[0] ? 8'h40 : 8'h00;
         // Bracketed shot k 1 asks for delay 0; the others never ask for a gate under 35 ns after insertion
         shot(k < 2 ? 0 : 5 + {$random(seed)} % 16, 1 + {$random(seed)} % 20,
            {$random(seed)} % 30, {k == 6 || k[0], 1'b1}, 1'b1);
      end
      overlight_alarm <= 1'b0;
      shot(5, 3, 0, 2'b00, 1'b0);
      hold <= 1'b1;
      shot(5, 3, 0, 2'b01, 1'b0);
      hold <= 1'b0;
      close_out;
   end
endmodule : test_intensifier_gate_bracket_timing
